/* design/bound_table.sv */
`timescale 1ns/1ns
`default_nettype none

module bound_table #(
  parameter int AW = 9,
  parameter int DW = 32
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // read port, data one cycle after address
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  // storage, no reset so it maps onto ram
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write, and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : bound_table

`default_nettype wire

/* design/limit_test_comparator.sv */
// Behaviour
// - two bound sets, every reading tested against both
// - failure reports direction and set, one wins
// - inside both sets gives in-range, no fail
// - set one resets to plus/minus one unit
// - set two resets to plus/minus two units
// - set two takes any values, even narrower
// - overflow counts high, no set or in-range
// - overflow tone_disabled_option flags low
// - test the processed chain result only
// - closed channel shows set one instead of in-range
// - tone mode disabled, on fail, on pass
// - on-fail mode sounds for any failure
// - on-pass mode sounds inside either set only
// - inside set two only uses lower pitch
// - tone mode from front panel only
// - simple scan shared bounds, advanced per channel
// - bounds unitless, read in active function unit
// - no limit test during continuity function
// - one readable enable, off means no status
// - status stored with reading, shown on recall
// - status attached to remote reading on request
// - equality with a bound counts as failure
`include "limit_test_params.svh"
`timescale 1ns/1ns
`default_nettype none

module limit_test_comparator #(
  parameter int CHAN_W = 7,
  parameter int TONE_HALF_NORM = `CLK_HZ / (2 * `TONE_NORM_HZ),
  parameter int TONE_HALF_LOW = `CLK_HZ / (2 * `TONE_LOW_HZ)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processed reading from the chain
  input wire logic reading_valid,
  input wire limit_test_pkg::reading_s reading,
  output logic busy,
  // front panel and function select
  input wire limit_test_pkg::tone_mode_e tone_mode_setting,
  input wire logic continuity_function,
  // reading buffer store and recall
  output logic status_valid,
  output limit_test_pkg::limit_status_s status,
  input wire logic recall_valid,
  input wire limit_test_pkg::limit_status_s recall_status,
  // display
  output limit_test_pkg::limit_status_s display_status,
  // remote reading output
  output logic result_valid,
  output logic [31:0] result_value,
  output logic result_tagged,
  output limit_test_pkg::limit_status_s result_status,
  // tone drive
  output logic tone_active,
  output logic tone_out
);

  localparam int AW = CHAN_W + 2;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // hit on upper and lower bound, equality counts as a hit
  function automatic logic [1:0] bound_check(input logic [31:0] val,
                                             input limit_test_pkg::bound_pair_s b);
    logic hi;
    logic lo;
    hi = $signed(val) >= $signed(b.upper);
    lo = $signed(val) <= $signed(b.lower);
    return {hi, lo};
  endfunction : bound_check

  // any word that lives in the address map
  function automatic logic is_mapped(input logic [31:0] a);
    logic hit;
    hit = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'h0) &&
          (a[7:0] <= `OFS_TAB_DATA);
    return hit;
  endfunction : is_mapped

  //////////////////////////////////////////////////////////////////////////////
  // state

  // present and next state
  limit_test_pkg::state_s s_q;
  limit_test_pkg::state_s s_d;

  // per-channel table access
  logic tab_wr;
  logic [AW-1:0] tab_rd_addr;
  logic [31:0] tab_rd_data;

  // comparison results for the held reading
  logic [1:0] hit_one;
  logic [1:0] hit_two;
  logic fail_any;

  // bus phases
  logic apb_setup;
  logic apb_commit;

  assign apb_setup = psel && !penable;
  assign apb_commit = psel && penable && s_q.pready;
  assign tab_wr = apb_commit && pwrite && (paddr[7:0] == `OFS_TAB_DATA) &&
                  is_mapped(paddr);

  // advanced scan entries, four words per channel
  assign tab_rd_addr = {s_q.rd.chan[CHAN_W-1:0], s_q.cnt[1:0]};

  // both sets against the same processed result
  // two-set test
  assign hit_one = bound_check(s_q.rd.value, s_q.work_one);
  assign hit_two = bound_check(s_q.rd.value, s_q.work_two);
  assign fail_any = s_q.rd.overflow || (hit_one != 2'b00) || (hit_two != 2'b00);

  //////////////////////////////////////////////////////////////////////////////
  // per-channel bound memory

  bound_table #(
    .AW(AW),
    .DW(32)
  ) u_table (
    .clk(pclk),
    .wr_en(tab_wr),
    .wr_addr(s_q.tab_idx[AW-1:0]),
    .wr_data(pwdata),
    .rd_addr(tab_rd_addr),
    .rd_data(tab_rd_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state

  // single combinational update of the whole state
  always_comb begin
    s_d = s_q;
    s_d.st_valid = 1'b0;
    s_d.res_valid = 1'b0;

    // writes take effect only at the completing edge
    if (apb_commit && pwrite && is_mapped(paddr)) begin
      case (paddr[7:0])
        `OFS_CTRL: begin
          s_d.en = pwdata[`CTRL_EN_BIT];
          s_d.adv = pwdata[`CTRL_ADV_BIT];
          s_d.fmt = pwdata[`CTRL_FMT_BIT];
        end
        `OFS_UB1: s_d.set_one.upper = pwdata;
        `OFS_LB1: s_d.set_one.lower = pwdata;
        `OFS_UB2: s_d.set_two.upper = pwdata;
        `OFS_LB2: s_d.set_two.lower = pwdata;
        `OFS_TAB_IDX: s_d.tab_idx = pwdata[15:0];
        // memory write happens beside, index steps for bursts
        `OFS_TAB_DATA: s_d.tab_idx = s_q.tab_idx + 16'h0001;
        // status is read only
        default: s_d.tab_idx = s_q.tab_idx;
      endcase
    end

    // apb: answer prepared in setup, so access completes with no wait
    // reads see the next state, so a back-to-back read after a write
    // returns the value that commits on its own setup edge
    s_d.pready = apb_setup;
    s_d.pslverr = apb_setup && !is_mapped(paddr);
    s_d.prdata = 32'h0000_0000;
    if (apb_setup && is_mapped(paddr)) begin
      case (paddr[7:0])
        `OFS_CTRL: begin
          s_d.prdata[`CTRL_EN_BIT] = s_d.en;
          s_d.prdata[`CTRL_ADV_BIT] = s_d.adv;
          s_d.prdata[`CTRL_FMT_BIT] = s_d.fmt;
        end
        `OFS_UB1: s_d.prdata = s_d.set_one.upper;
        `OFS_LB1: s_d.prdata = s_d.set_one.lower;
        `OFS_UB2: s_d.prdata = s_d.set_two.upper;
        `OFS_LB2: s_d.prdata = s_d.set_two.lower;
        // live status plus sequencer busy
        `OFS_STATUS: s_d.prdata = {23'h00_0000, s_q.fsm != limit_test_pkg::ST_IDLE,
                                   s_q.tone_act, s_q.tone_low, s_q.st};
        `OFS_TAB_IDX: s_d.prdata = {16'h0000, s_d.tab_idx};
        // table data is write only
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end

    // sequencer: readings arriving while busy are not taken
    case (s_q.fsm)
      limit_test_pkg::ST_IDLE: begin
        // input is already the rel/math/ratio/average result
        if (reading_valid) begin
          s_d.rd = reading;
          s_d.cnt = 3'h0;
          if (s_q.adv) begin
            s_d.fsm = limit_test_pkg::ST_FETCH;
          end else begin
            s_d.work_one = s_q.set_one;
            s_d.work_two = s_q.set_two;
            s_d.fsm = limit_test_pkg::ST_COMP;
          end
        end
      end
      limit_test_pkg::ST_FETCH: begin
        // table data trail the address by one cycle
        s_d.cnt = s_q.cnt + 3'h1;
        case (s_q.cnt)
          `TAB_UB1: s_d.work_one.upper = tab_rd_data;
          `TAB_LB1: s_d.work_one.lower = tab_rd_data;
          `TAB_UB2: s_d.work_two.upper = tab_rd_data;
          `TAB_LB2: begin
            s_d.work_two.lower = tab_rd_data;
            s_d.fsm = limit_test_pkg::ST_COMP;
          end
          // first address still in flight
          default: s_d.work_one = s_q.work_one;
        endcase
      end
      limit_test_pkg::ST_COMP: begin
        // evaluate once, hold until the next reading
        s_d.fsm = limit_test_pkg::ST_IDLE;
        s_d.st = '0;
        s_d.tone_act = 1'b0;
        s_d.tone_low = 1'b0;
        if (s_q.en && !continuity_function) begin
          s_d.st_valid = 1'b1;
          if (s_q.rd.overflow) begin
            s_d.st.overflow = 1'b1;
            s_d.st.high = 1'b1;
          end else if (hit_one != 2'b00) begin
            s_d.st.high = hit_one[1];
            s_d.st.low = hit_one[0];
            s_d.st.set_idx = 2'h1;
          end else if (hit_two != 2'b00) begin
            s_d.st.high = hit_two[1];
            s_d.st.low = hit_two[0];
            s_d.st.set_idx = 2'h2;
          end else if (s_q.rd.closed) begin
            s_d.st.set_idx = 2'h1;
          end else begin
            s_d.st.in_range = 1'b1;
          end
          // mode comes only from the panel input
          case (tone_mode_setting)
            limit_test_pkg::TONE_ON_FAIL: s_d.tone_act = fail_any;
            limit_test_pkg::TONE_ON_PASS: begin
              s_d.tone_act = !s_q.rd.overflow &&
                             ((hit_one == 2'b00) || (hit_two == 2'b00));
              s_d.tone_low = hit_one != 2'b00;
            end
            default: s_d.tone_act = 1'b0;
          endcase
        end
        // bounds compared as plain numbers, unit set by function
        s_d.disp = s_d.st;
        // remote reading carries status on request
        s_d.res_valid = 1'b1;
        s_d.res_value = s_q.rd.value;
        s_d.res_tagged = s_q.fmt && s_d.st_valid;
        s_d.res_status = s_d.res_tagged ? s_d.st : '0;
      end
      // unused encoding returns home
      default: s_d.fsm = limit_test_pkg::ST_IDLE;
    endcase

    // recalled reading shows its stored status
    if (recall_valid) begin
      s_d.disp = recall_status;
    end

    // tone divider: terminal count is the one-cycle toggle enable
    if (s_q.tone_act) begin
      if (s_q.tone_cnt == 32'(s_q.tone_low ? TONE_HALF_LOW - 1 : TONE_HALF_NORM - 1)) begin
        s_d.tone_cnt = 32'h0000_0000;
        s_d.tone_out = !s_q.tone_out;
      end else begin
        s_d.tone_cnt = s_q.tone_cnt + 32'h0000_0001;
      end
    end else begin
      // silence resets the phase so each tone starts clean
      s_d.tone_cnt = 32'h0000_0000;
      s_d.tone_out = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // all state in one register, constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.set_one.upper <= `RST_UB1;
      s_q.set_one.lower <= `RST_LB1;
      s_q.set_two.upper <= `RST_UB2;
      s_q.set_two.lower <= `RST_LB2;
      s_q.fsm <= limit_test_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from the state register except busy, decoded from fsm

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign busy = s_q.fsm != limit_test_pkg::ST_IDLE;
  assign status_valid = s_q.st_valid;
  assign status = s_q.st;
  assign display_status = s_q.disp;
  assign result_valid = s_q.res_valid;
  assign result_value = s_q.res_value;
  assign result_tagged = s_q.res_tagged;
  assign result_status = s_q.res_status;
  assign tone_active = s_q.tone_act;
  assign tone_out = s_q.tone_out;

endmodule : limit_test_comparator

`default_nettype wire

/* design/limit_test_params.svh */
`ifndef LIMIT_TEST_PARAMS_SVH
`define LIMIT_TEST_PARAMS_SVH

// register byte offsets on the apb bus
`define OFS_CTRL 8'h00
`define OFS_UB1 8'h04
`define OFS_LB1 8'h08
`define OFS_UB2 8'h0C
`define OFS_LB2 8'h10
`define OFS_STATUS 8'h14
`define OFS_TAB_IDX 8'h18
`define OFS_TAB_DATA 8'h1C

// control register bit positions
`define CTRL_EN_BIT 0
`define CTRL_ADV_BIT 1
`define CTRL_FMT_BIT 2

// bound reset values, signed 16.16 fixed point, one unit = 0x1_0000
`define RST_UB1 32'h0001_0000
`define RST_LB1 32'hFFFF_0000
`define RST_UB2 32'h0002_0000
`define RST_LB2 32'hFFFE_0000

// per-channel table entry order within one channel
`define TAB_UB1 3'h1
`define TAB_LB1 3'h2
`define TAB_UB2 3'h3
`define TAB_LB2 3'h4

// clock and tone pitch figures
`define CLK_HZ 125000000
`define TONE_NORM_HZ 2000
`define TONE_LOW_HZ 1000

`endif

/* design/limit_test_pkg.sv */
package limit_test_pkg;

  // front panel tone mode selection
  typedef enum logic [1:0] {
    TONE_DISABLED_OPTION = 2'h0,
    TONE_ON_FAIL = 2'h1,
    TONE_ON_PASS = 2'h2
  } tone_mode_e;

  // sequencer states, gray along idle -> fetch -> compare
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_COMP = 2'b11
  } fsm_e;

  // limit outcome of one reading
  typedef struct packed {
    logic in_range;
    logic high;
    logic low;
    logic overflow;
    logic [1:0] set_idx;
  } limit_status_s;

  // one processed reading from the chain
  typedef struct packed {
    logic [31:0] value;
    logic overflow;
    logic closed;
    logic [15:0] chan;
  } reading_s;

  // one bound pair
  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
  } bound_pair_s;

  // whole state of the comparator
  typedef struct packed {
    logic en;
    logic adv;
    logic fmt;
    bound_pair_s set_one;
    bound_pair_s set_two;
    logic [15:0] tab_idx;
    fsm_e fsm;
    logic [2:0] cnt;
    reading_s rd;
    bound_pair_s work_one;
    bound_pair_s work_two;
    limit_status_s st;
    logic st_valid;
    logic res_valid;
    logic [31:0] res_value;
    logic res_tagged;
    limit_status_s res_status;
    limit_status_s disp;
    logic tone_act;
    logic tone_low;
    logic [31:0] tone_cnt;
    logic tone_out;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

endpackage : limit_test_pkg

/* verif/limit_test_comparator_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module limit_test_comparator_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // reading side and panel
  input wire logic reading_valid,
  input wire logic busy,
  input wire logic continuity_function,
  input wire limit_test_pkg::tone_mode_e tone_mode_setting,
  // results
  input wire logic status_valid,
  input wire limit_test_pkg::limit_status_s status,
  input wire logic recall_valid,
  input wire limit_test_pkg::limit_status_s recall_status,
  input wire limit_test_pkg::limit_status_s display_status,
  input wire logic result_valid,
  input wire logic tone_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a reading the sequencer accepts
  wire logic take = reading_valid && !busy;
  ////////////////////////////////////////////////////////////////
  property p_apb; psel && !penable |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("apb answer late");
  // simple scan answers after two edges, advanced after seven
  property p_turn; take |-> ##[2:7] result_valid; endproperty
  a_turn: assert property (p_turn) else $error("no result after reading");
  property p_hold; !result_valid |-> $stable(status); endproperty
  a_hold: assert property (p_hold) else $error("status moved between readings");
  property p_in; status_valid && status.in_range |-> !status.high && !status.low; endproperty
  a_in: assert property (p_in) else $error("in range with fail flag");
  property p_dir;
    status_valid && (status.high || status.low) && !status.overflow
      |-> status.set_idx inside {2'h1, 2'h2};
  endproperty
  a_dir: assert property (p_dir) else $error("failure without set index");
  property p_ovf;
    status_valid && status.overflow |-> status.set_idx == 2'h0 && !status.in_range;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow shows set or in range");
  property p_ovf_low; status_valid && status.overflow |-> status.high && !status.low; endproperty
  a_ovf_low: assert property (p_ovf_low) else $error("overflow not high only");
  property p_continuity_function; take && continuity_function |=> !status_valid [*6]; endproperty
  a_continuity_function: assert property (p_continuity_function) else $error("status in continuity");
  property p_recall; recall_valid |=> display_status == $past(recall_status); endproperty
  a_recall: assert property (p_recall) else $error("recall not shown");
  property p_quiet;
    result_valid && tone_mode_setting == limit_test_pkg::TONE_DISABLED_OPTION |-> !tone_active;
  endproperty
  a_quiet: assert property (p_quiet) else $error("tone while disabled");
  property p_fail;
    result_valid && status_valid && (status.high || status.low)
      && tone_mode_setting == limit_test_pkg::TONE_ON_FAIL |-> tone_active;
  endproperty
  a_fail: assert property (p_fail) else $error("no tone on failure");
  // main scenarios seen
  c_ovf: cover property (status_valid && status.overflow);
  c_recall: cover property (recall_valid);
  c_tone: cover property (result_valid && tone_active);
endmodule : limit_test_comparator_checker
bind limit_test_comparator limit_test_comparator_checker i_chk (.pclk, .presetn, .psel,
  .penable, .pready, .reading_valid, .busy, .continuity_function, .tone_mode_setting,
  .status_valid, .status, .recall_valid, .recall_status, .display_status, .result_valid,
  .tone_active);
`default_nettype wire

/* verif/limit_test_comparator_test.sv */
`timescale 1ns/1ns
`default_nettype none
module limit_test_comparator_test;
  // clock, reset and apb
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, result_value;
  logic pready, pslverr, reading_valid, busy, status_valid, result_valid;
  logic result_tagged, tone_active, tone_out;
  limit_test_pkg::reading_s reading;
  // panel, function and recall
  limit_test_pkg::tone_mode_e tone_mode_setting = limit_test_pkg::TONE_DISABLED_OPTION;
  logic continuity_function = 1'b0;
  logic recall_valid = 1'b0;
  limit_test_pkg::limit_status_s recall_status = 6'h00;
  limit_test_pkg::limit_status_s status, display_status, result_status;
  int err_total = 0;
  int check_count = 0;
  always #4 pclk = ~pclk;
  limit_test_comparator #(.CHAN_W(7), .TONE_HALF_NORM(4), .TONE_HALF_LOW(8))
    i_limit_test_comparator (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .reading_valid, .reading, .busy, .tone_mode_setting,
    .continuity_function, .status_valid, .status, .recall_valid, .recall_status,
    .display_status, .result_valid, .result_value, .result_tagged, .result_status,
    .tone_active, .tone_out);
  reading_chain_model i_reading_chain_model (.pclk, .reading_valid, .reading);
  ////////////////////////////////////////////////////////////////
  // compare helpers, one per result kind
  task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk_w
  task automatic chk_s(input string n, input limit_test_pkg::limit_status_s e,
                       input limit_test_pkg::limit_status_s g);
    chk_w(n, {26'h0, e}, {26'h0, g});
  endtask : chk_s
  task automatic chk_b(input string n, input logic e, input logic g);
    chk_w(n, {31'h0, e}, {31'h0, g});
  endtask : chk_b
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no bound here: pready or, failing that, the watchdog ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call tone_disabled_option re-drives psel in this step
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input string n, input logic [31:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk_w(n, x, r);
  endtask : rd_chk
  // send a reading and wait, bounded, for its result
  task automatic meas(input logic [31:0] v, input logic ovf, input logic cl);
    int n;
    n = 0;
    i_reading_chain_model.send(v, ovf, cl);
    @(posedge pclk);
    chk_b("busy", 1'b1, busy);
    while (result_valid !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk_b("result_valid", 1'b1, result_valid);
  endtask : meas
  ////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [31:0] r;
    logic e;
    rd_chk("ub1", 32'h0000_0004, 32'h0001_0000);
    rd_chk("lb1", 32'h0000_0008, 32'hFFFF_0000);
    rd_chk("ub2", 32'h0000_000C, 32'h0002_0000);
    rd_chk("lb2", 32'h0000_0010, 32'hFFFE_0000);
    rd_chk("ctrl", 32'h0000_0000, 32'h0000_0000);
    apb(1'b0, 32'h0000_0020, 32'h0000_0000, r, e);
    chk_b("unmapped", 1'b1, e);
    $display("test_reset done");
  endtask : test_reset
  // in, high, both fail, low, equality, overflow negative, closed channel
  task automatic test_status();
    logic [31:0] v [8] = '{32'h0000_8000, 32'h0001_8000, 32'h0002_8000, 32'hFFFE_8000,
                           32'h0001_0000, 32'hFFFF_0000, 32'hFFFD_0000, 32'h0000_0000};
    logic [5:0] x [8] = '{6'h20, 6'h11, 6'h11, 6'h09, 6'h11, 6'h09, 6'h14, 6'h01};
    wr(32'h0000_0000, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      meas(v[i], i == 6, i == 7);
      chk_b("status_valid", 1'b1, status_valid);
      chk_s("status", x[i], status);
      chk_s("display", x[i], display_status);
    end
    $display("test_status done");
  endtask : test_status
  // set two inside set one fails first
  task automatic test_narrow();
    wr(32'h0000_000C, 32'h0000_8000);
    wr(32'h0000_0010, 32'hFFFF_8000);
    meas(32'h0000_C000, 1'b0, 1'b0);
    chk_s("narrow", 6'h12, status);
    wr(32'h0000_000C, 32'h0002_0000);
    wr(32'h0000_0010, 32'hFFFE_0000);
    $display("test_narrow done");
  endtask : test_narrow
  // every tone mode, pitch read back from the status word
  task automatic test_tone();
    logic [1:0] m [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [31:0] v [7] = '{32'h0000_8000, 32'h0001_8000, 32'h0001_8000, 32'h0000_8000,
                           32'h0000_8000, 32'h0001_8000, 32'h0002_8000};
    logic a [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] r;
    logic e, p;
    int t;
    for (int i = 0; i < 7; i++) begin
      tone_mode_setting <= limit_test_pkg::tone_mode_e'(m[i]);
      @(posedge pclk);
      meas(v[i], 1'b0, 1'b0);
      chk_b("tone_active", a[i], tone_active);
      apb(1'b0, 32'h0000_0014, 32'h0000_0000, r, e);
      // in on-pass mode, lower pitch flagged whenever set one has failed
      if (m[i] == 2'h2) chk_b("tone_low", i >= 5, r[6]);
      p = tone_out;
      t = 0;
      repeat (20) begin
        @(posedge pclk);
        if (tone_out !== p) t++;
        p = tone_out;
      end
      chk_b("tone_out", a[i], t > 0);
    end
    tone_mode_setting <= limit_test_pkg::TONE_DISABLED_OPTION;
    $display("test_tone done");
  endtask : test_tone
  // continuity, remote tagging, limits off
  task automatic test_off();
    continuity_function <= 1'b1;
    meas(32'h0001_8000, 1'b0, 1'b0);
    chk_b("continuity_function", 1'b0, status_valid);
    continuity_function <= 1'b0;
    wr(32'h0000_0000, 32'h0000_0005);
    meas(32'h0001_8000, 1'b0, 1'b0);
    chk_b("tagged", 1'b1, result_tagged);
    chk_w("value", 32'h0001_8000, result_value);
    chk_s("remote", 6'h11, result_status);
    wr(32'h0000_0000, 32'h0000_0000);
    meas(32'h0001_8000, 1'b0, 1'b0);
    chk_b("off", 1'b0, status_valid);
    chk_s("off status", 6'h00, status);
    $display("test_off done");
  endtask : test_off
  // advanced scan: channel three gets its own bounds, set two narrower
  task automatic test_adv();
    wr(32'h0000_0018, 32'h0000_000C);
    wr(32'h0000_001C, 32'h0000_8000);
    wr(32'h0000_001C, 32'hFFFF_8000);
    wr(32'h0000_001C, 32'h0000_4000);
    wr(32'h0000_001C, 32'hFFFF_C000);
    rd_chk("tab_idx", 32'h0000_0018, 32'h0000_0010);
    wr(32'h0000_0000, 32'h0000_0003);
    meas(32'h0000_6000, 1'b0, 1'b0);
    chk_s("adv set two", 6'h12, status);
    meas(32'hFFFF_4000, 1'b0, 1'b0);
    chk_s("adv set one", 6'h09, status);
    $display("test_adv done");
  endtask : test_adv
  task automatic test_recall();
    recall_status <= 6'h0A;
    recall_valid <= 1'b1;
    @(posedge pclk);
    recall_valid <= 1'b0;
    @(posedge pclk);
    chk_s("recall", 6'h0A, display_status);
    $display("test_recall done");
  endtask : test_recall
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_status();
    test_narrow();
    test_tone();
    test_off();
    test_adv();
    test_recall();
    final_report();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule : limit_test_comparator_test
`default_nettype wire

/* verif/reading_chain_model.sv */
`timescale 1ns/1ns
`default_nettype none
// stands in for the processing chain: hands over finished results only
module reading_chain_model (
  // clock
  input wire logic pclk,
  // result handed to the comparator
  output logic reading_valid,
  output limit_test_pkg::reading_s reading
);
  // idle at time zero
  initial begin
    reading_valid = 1'b0;
    reading = '0;
  end
  task automatic send(input logic [31:0] v, input logic ovf, input logic cl);
    reading_valid <= 1'b1;
    reading <= {v, ovf, cl, 16'h0003};
    @(posedge pclk);
    reading_valid <= 1'b0;
    // released: inverse so stale data cannot pass as held
    reading <= ~reading;
  endtask : send
endmodule : reading_chain_model
`default_nettype wire
